// ==== src/reset_cause_recorder.sv ====
`timescale 1ns/1ps
module reset_cause_recorder
  import rcr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic powerOnEvt,
  input wire logic brownoutEvt,
  input wire logic lowPowerBrownoutEvt,
  input wire logic external_reset_pin_n,
  input wire logic watchdogTimeout,
  input wire logic resetInstr,
  input wire logic stackOverflow,
  input wire logic stackUnderflow,
  input wire logic irqWake,
  input wire logic pendingIrq,
  input wire logic asleep,
  input wire logic borReady,
  input wire logic [15:0] curPc,
  output logic [15:0] startPc_ff,
  output logic startPcLoad_ff,
  output logic pushReturn_ff,
  output logic coreReset_ff,
  output logic global_irq_enable_ff,
  output logic irq_ff
);
  logic [1:0] pinSync_ff;
  logic [1:0] borRdySync_ff;
  logic pinPrev_ff;
  logic [7:0] power_control_flags;
  logic [4:0] statusQ;
  logic [1:0] borCtl_ff;
  logic stkEn_ff;
  logic [NCAUSE-1:0] irqStat_ff;
  logic [NCAUSE-1:0] irqMask_ff;
  logic vectorPending_ff;
  logic ackPending_ff;
  logic [NCAUSE-1:0] ev;
  logic anyReset;
  logic brownAny;
  logic pinFall;
  logic wdtRst;
  logic wdtWake;
  logic accept;
  logic wrEn;
  logic wrPcon;
  logic wrStat;
  logic [7:0] hwSet;
  logic [7:0] hwClr;
  logic [4:0] stSet;
  logic [4:0] stClr;

  // pin is from outside the clock domain
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pinSync_ff <= 2'h3;
      borRdySync_ff <= 2'h0;
      pinPrev_ff <= 1'b1;
    end else if (clkEn) begin
      pinSync_ff <= {pinSync_ff[0], external_reset_pin_n};
      borRdySync_ff <= {borRdySync_ff[0], borReady};
      pinPrev_ff <= pinSync_ff[1];
    end
  end

  assign pinFall = pinPrev_ff & ~pinSync_ff[1];
  assign brownAny = brownoutEvt | lowPowerBrownoutEvt;
  assign wdtRst = watchdogTimeout & ~asleep;
  assign wdtWake = watchdogTimeout & asleep;

  // power-on masks brown-out; the other causes are not masked by brown-out here
  always_comb begin
    ev = '0;
    ev[EV_POR] = powerOnEvt;
    ev[EV_BOR] = brownAny & ~powerOnEvt;
    ev[EV_PIN] = pinFall & ~asleep;
    ev[EV_PINSLP] = pinFall & asleep;
    ev[EV_WDT] = wdtRst;
    ev[EV_WDTWAKE] = wdtWake;
    ev[EV_IRQWAKE] = irqWake & asleep & ~pinFall & ~wdtWake;
    ev[EV_RI] = resetInstr;
    ev[EV_STK] = stkEn_ff & (stackOverflow | stackUnderflow);
  end

  assign anyReset = ev[EV_POR] | ev[EV_BOR] | ev[EV_PIN] | ev[EV_PINSLP] | ev[EV_WDT]
    | ev[EV_RI] | ev[EV_STK];

  assign accept = (read | write) & ~ackPending_ff;
  // a write lands only at the edge where waitrequest is seen low
  assign wrEn = write & ackPending_ff;
  assign wrPcon = wrEn & (address == {1'b0, ADDR_PWRCTL});
  assign wrStat = wrEn & (address == {1'b0, ADDR_STATUS});

  // set and clear requests per power control bit
  always_comb begin
    hwSet = '0;
    hwClr = '0;
    if (ev[EV_POR]) begin
      hwClr = 8'hc3;
      hwSet = 8'h1c;
    end else if (ev[EV_BOR]) begin
      hwClr = 8'hc1;
      hwSet = 8'h0c;
    end else begin
      hwClr[BIT_PIN] = ev[EV_PIN] | ev[EV_PINSLP];
      hwClr[BIT_WDT] = ev[EV_WDT];
      hwClr[BIT_RI] = ev[EV_RI];
      hwSet[BIT_OVF] = ev[EV_STK] & stackOverflow;
      hwSet[BIT_UNF] = ev[EV_STK] & stackUnderflow;
    end
  end

  // status: timeout and powerdown, and power-on also clears the low bits; otherwise the low bits belong to the core
  always_comb begin
    stSet = '0;
    stClr = '0;
    if (ev[EV_POR]) begin
      stSet = STATUS_POR;
      stClr = ~STATUS_POR;
    end else if (ev[EV_BOR]) begin
      stSet = STATUS_POR;
    end else if (ev[EV_PINSLP]) begin
      stSet[BIT_TO] = 1'b1;
      stClr[BIT_PD] = 1'b1;
    end else if (ev[EV_WDT]) begin
      stClr[BIT_TO] = 1'b1;
    end else if (ev[EV_WDTWAKE]) begin
      stClr[BIT_TO] = 1'b1;
      stClr[BIT_PD] = 1'b1;
    end else if (ev[EV_IRQWAKE]) begin
      stSet[BIT_TO] = 1'b1;
      stClr[BIT_PD] = 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_power_control_flags
      if (gi == 5) begin : g_unimpl
        assign power_control_flags[gi] = 1'b0;
      end else begin : g_impl
        flag_bit #(.RESET_VAL(PWRCTL_POR[gi])) u_flag (
          .mclk(mclk),
          .rst_n(rst_n),
          .clkEn(clkEn),
          .hwSet(hwSet[gi]),
          .hwClr(hwClr[gi]),
          .swWr(wrPcon),
          .swVal(writedata[gi] & ((gi < 6) | power_control_flags[gi])),
          .q(power_control_flags[gi])
        );
      end
    end
    for (gi = 0; gi < 5; gi++) begin : g_stat
      flag_bit #(.RESET_VAL(STATUS_POR[gi])) u_flag (
        .mclk(mclk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .hwSet(stSet[gi]),
        .hwClr(stClr[gi]),
        .swWr(wrStat & (gi < 3)),
        .swVal(writedata[gi]),
        .q(statusQ[gi])
      );
    end
  endgenerate

  // pc start point and core restart
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      startPc_ff <= PC_RESET;
      startPcLoad_ff <= 1'b1;
      coreReset_ff <= 1'b1;
      pushReturn_ff <= 1'b0;
      vectorPending_ff <= 1'b0;
    end else if (clkEn) begin
      startPcLoad_ff <= 1'b0;
      coreReset_ff <= anyReset;
      pushReturn_ff <= 1'b0;
      if (anyReset) begin
        startPc_ff <= PC_RESET;
        startPcLoad_ff <= 1'b1;
        vectorPending_ff <= 1'b0;
      end else if (vectorPending_ff) begin
        // next instruction ran first, now take the vector
        startPc_ff <= PC_VECTOR;
        startPcLoad_ff <= 1'b1;
        pushReturn_ff <= 1'b1;
        vectorPending_ff <= 1'b0;
      end else if (ev[EV_WDTWAKE] | ev[EV_IRQWAKE]) begin
        startPc_ff <= curPc + 16'h0001;
        startPcLoad_ff <= 1'b1;
        vectorPending_ff <= ev[EV_IRQWAKE] & global_irq_enable_ff & pendingIrq;
      end
    end
  end

  // global enable and stack reset enable live in the control word
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      global_irq_enable_ff <= 1'b0;
      stkEn_ff <= 1'b1;
    end else if (clkEn) begin
      if (anyReset) begin
        global_irq_enable_ff <= 1'b0;
      end else if (vectorPending_ff) begin
        global_irq_enable_ff <= 1'b0;
      end else if (wrEn & (address == {1'b1, ADDR_CTRL})) begin
        global_irq_enable_ff <= writedata[BIT_GIE];
        stkEn_ff <= writedata[BIT_STKEN];
      end
    end
  end

  // brownout control: enable and fast-start bits held, ready is live
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      borCtl_ff <= BORCTL_POR;
    end else if (clkEn) begin
      if (ev[EV_POR] | ev[EV_BOR]) begin
        borCtl_ff <= BORCTL_POR;
      end else if (wrEn & (address == {1'b0, ADDR_BORCTL})) begin
        borCtl_ff <= writedata[BIT_SBOREN:BIT_BORFS];
      end
    end
  end

  // sticky cause bits, write one to clear; a new event wins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irqStat_ff <= '0;
      irqMask_ff <= '0;
      irq_ff <= 1'b0;
    end else if (clkEn) begin
      if (wrEn & (address == {1'b0, ADDR_IRQSTAT})) begin
        irqStat_ff <= (irqStat_ff & ~writedata[NCAUSE-1:0]) | ev;
      end else begin
        irqStat_ff <= irqStat_ff | ev;
      end
      if (wrEn & (address == {1'b1, ADDR_IRQMASK})) begin
        irqMask_ff <= writedata[NCAUSE-1:0];
      end
      irq_ff <= |(irqStat_ff & irqMask_ff);
    end
  end

  // bus: one wait cycle, then answer with registered data
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ackPending_ff <= 1'b0;
      readdata <= '0;
    end else if (clkEn) begin
      ackPending_ff <= accept;
      if (accept & read) begin
        case (address)
          {1'b0, ADDR_PWRCTL}: readdata <= {24'h0, power_control_flags};
          {1'b0, ADDR_STATUS}: readdata <= {27'h0, statusQ};
          {1'b0, ADDR_BORCTL}: readdata <= {24'h0, borCtl_ff, 5'h00, borRdySync_ff[1]};
          {1'b0, ADDR_IRQSTAT}: readdata <= {23'h0, irqStat_ff};
          {1'b1, ADDR_IRQMASK}: readdata <= {23'h0, irqMask_ff};
          {1'b1, ADDR_CTRL}: readdata <= {30'h0, stkEn_ff, global_irq_enable_ff};
          {1'b1, ADDR_PCREG}: readdata <= {16'h0, startPc_ff};
          default: readdata <= '0;
        endcase
      end
    end
  end

  assign waitrequest = ~ackPending_ff;

  AST_POR_FLAGS: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && powerOnEvt |=> power_control_flags[7:1] == 7'h0e && statusQ[4:3] == 2'h3)
    else $error("power-on flags wrong");
  AST_BOR_FLAGS: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && ev[EV_BOR] |=> power_control_flags[BIT_BOR] == 1'b0 && power_control_flags[7:6] == 2'h0 && power_control_flags[3:2] == 2'h3)
    else $error("brown-out flags wrong");
  AST_PIN_RUN: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && ev[EV_PIN] && !ev[EV_POR] && !ev[EV_BOR] |=> !power_control_flags[BIT_PIN])
    else $error("pin flag not cleared");
  AST_PIN_SLEEP: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && ev[EV_PINSLP] && !brownAny && !powerOnEvt |=> statusQ[4:3] == 2'h2)
    else $error("pin sleep status wrong");
  AST_WDT: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && ev[EV_WDT] && !brownAny && !powerOnEvt |=> !power_control_flags[BIT_WDT] && !statusQ[BIT_TO])
    else $error("watchdog flags wrong");
  AST_WAKE_PC: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && ev[EV_WDTWAKE] && !anyReset && !vectorPending_ff
    |=> startPc_ff == $past(curPc) + 16'h0001 && startPcLoad_ff)
    else $error("wake pc wrong");
  AST_RI: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && resetInstr && !brownAny && !powerOnEvt |=> !power_control_flags[BIT_RI] && startPc_ff == PC_RESET)
    else $error("reset instruction handling wrong");
  AST_UNIMPL: assert property (@(posedge mclk) disable iff (!rst_n)
    !power_control_flags[5])
    else $error("bit 5 not zero");
  AST_GIE_CLR: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && anyReset |=> !global_irq_enable_ff)
    else $error("enable survived reset");
  AST_HW_WINS: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && wrPcon && ev[EV_STK] && stackOverflow && !powerOnEvt && !ev[EV_BOR]
    |=> power_control_flags[BIT_OVF])
    else $error("write beat hardware set");
endmodule : reset_cause_recorder

// ==== src/rcr_pkg.sv ====
package rcr_pkg;
  // register byte addresses on the word bus
  localparam logic [3:0] ADDR_PWRCTL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_BORCTL = 4'h8;
  localparam logic [3:0] ADDR_IRQSTAT = 4'hc;
  localparam logic [3:0] ADDR_IRQMASK = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h4;
  localparam logic [3:0] ADDR_PCREG = 4'h8;
  // second page selector bit of the 5-bit address
  localparam int ADDR_W = 5;
  // power control field positions
  localparam int BIT_OVF = 7;
  localparam int BIT_UNF = 6;
  localparam int BIT_WDT = 4;
  localparam int BIT_PIN = 3;
  localparam int BIT_RI = 2;
  localparam int BIT_POR = 1;
  localparam int BIT_BOR = 0;
  // core status field positions
  localparam int BIT_TO = 4;
  localparam int BIT_PD = 3;
  // brownout control field positions
  localparam int BIT_SBOREN = 7;
  localparam int BIT_BORFS = 6;
  localparam int BIT_BORRDY = 0;
  // control register field positions
  localparam int BIT_GIE = 0;
  localparam int BIT_STKEN = 1;
  // values after power-on
  localparam logic [7:0] PWRCTL_POR = 8'h1c;
  localparam logic [4:0] STATUS_POR = 5'h18;
  localparam logic [1:0] BORCTL_POR = 2'h2;
  // program counter start points
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] PC_VECTOR = 16'h0004;
  // interrupt status bits, one per cause
  localparam int NCAUSE = 9;
  typedef enum {
    EV_POR, EV_BOR, EV_PIN, EV_PINSLP, EV_WDT, EV_WDTWAKE, EV_IRQWAKE, EV_RI, EV_STK
  } cause_t;
endpackage : rcr_pkg

// ==== src/flag_bit.sv ====
`timescale 1ns/1ps
// one software-visible flag; hardware set and clear beat a firmware write
module flag_bit #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic hwSet,
  input wire logic hwClr,
  input wire logic swWr,
  input wire logic swVal,
  output logic q
);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RESET_VAL;
    end else if (clkEn) begin
      if (hwSet) begin
        q <= 1'b1;
      end else if (hwClr) begin
        q <= 1'b0;
      end else if (swWr) begin
        q <= swVal;
      end
    end
  end
endmodule : flag_bit

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
  import rcr_pkg::*;
;
  logic mclk, rst_n, clkEn, read, write, pinN, pendingIrq, asleep, borReady;
  logic [4:0] address;
  logic [31:0] writedata, readdata, q, wd;
  logic waitrequest, startPcLoad_ff, pushReturn_ff, coreReset_ff, gieOut, irq_ff;
  logic [7:0] ev;
  logic [15:0] curPc, startPc_ff, pc;
  logic [7:0] power_control_flags;
  logic [4:0] st;
  logic [8:0] irqSt, mask;
  logic global_irq_enable;
  int cmp_count, miscompares, cycles, pushes, c, resets, loads;
  reset_cause_recorder dut (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .powerOnEvt(ev[0]), .brownoutEvt(ev[1]),
    .lowPowerBrownoutEvt(ev[2]), .external_reset_pin_n(pinN), .watchdogTimeout(ev[3]),
    .resetInstr(ev[4]), .stackOverflow(ev[5]), .stackUnderflow(ev[6]), .irqWake(ev[7]),
    .pendingIrq(pendingIrq), .asleep(asleep), .borReady(borReady), .curPc(curPc),
    .startPc_ff(startPc_ff), .startPcLoad_ff(startPcLoad_ff), .pushReturn_ff(pushReturn_ff),
    .coreReset_ff(coreReset_ff), .global_irq_enable_ff(gieOut), .irq_ff(irq_ff));
  always #20 mclk = ~mclk;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  // the request stands until waitrequest is sampled low; only the timeout ends a hang
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic rdchk(input string nm, input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, q, exp);
  endtask : rdchk
  task automatic pulse(input int k);
    @(posedge mclk);
    ev[k] <= 1'b1;
    @(posedge mclk);
    ev <= 8'h00;
  endtask : pulse
  always @(posedge mclk) begin
    cycles++;
    if (pushReturn_ff === 1'b1) pushes++;
    if (coreReset_ff === 1'b1) resets++;
    if (startPcLoad_ff === 1'b1) loads++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    mclk = 0; rst_n = 0; clkEn = 1; read = 0; write = 0; address = 0; writedata = 0;
    pinN = 1; pendingIrq = 0; asleep = 0; borReady = 1; curPc = 0; ev = 0;
    c = $urandom(32'h66501a65);
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rdchk("power_control_flags", {1'b0, ADDR_PWRCTL}, 32'h1c);
    rdchk("status", {1'b0, ADDR_STATUS}, 32'h18);
    rdchk("borctl", {1'b0, ADDR_BORCTL}, 32'h81);
    chk("gie", 32'(gieOut), 32'h0);
    bus(1'b1, {1'b0, ADDR_PWRCTL}, 32'hff);
    rdchk("power_control_flags wr", {1'b0, ADDR_PWRCTL}, 32'h1f);
    $display("reset values test done");
    power_control_flags = 8'h1f;
    st = 5'h18;
    for (int i = 0; i < 60; i++) begin
      c = (i < 11) ? i : $urandom_range(0, 10);
      wd = $urandom;
      bus(1'b1, {1'b0, ADDR_PWRCTL}, wd);
      power_control_flags = {power_control_flags[7] & wd[7], power_control_flags[6] & wd[6], 1'b0, wd[4:0]};
      wd = $urandom;
      bus(1'b1, {1'b0, ADDR_STATUS}, wd);
      st[2:0] = wd[2:0];
      global_irq_enable = $urandom;
      bus(1'b1, {1'b1, ADDR_CTRL}, {30'h0, 1'b1, global_irq_enable});
      mask = $urandom;
      bus(1'b1, {1'b1, ADDR_IRQMASK}, {23'h0, mask});
      bus(1'b1, {1'b0, ADDR_IRQSTAT}, 32'h1ff);
      curPc <= $urandom;
      pendingIrq <= $urandom;
      asleep <= (c == 4 || c == 6 || c == 7);
      @(posedge mclk);
      pushes = 0;
      resets = 0;
      loads = 0;
      pc = 16'h0000;
      irqSt = 9'h0;
      case (c)
        0: begin
          pulse(0);
          power_control_flags = 8'h1c;
          st = 5'h18;
          irqSt[EV_POR] = 1'b1;
        end
        1, 2: begin
          pulse(c);
          power_control_flags = {3'b000, power_control_flags[4], 2'b11, power_control_flags[1], 1'b0};
          st[4:3] = 2'b11;
          irqSt[EV_BOR] = 1'b1;
        end
        3, 4: begin
          pinN <= 1'b0;
          repeat (6) @(posedge mclk);
          pinN <= 1'b1;
          power_control_flags[3] = 1'b0;
          if (c == 4) st[4:3] = 2'b10;
          irqSt[c == 4 ? EV_PINSLP : EV_PIN] = 1'b1;
        end
        5: begin
          pulse(3);
          power_control_flags[4] = 1'b0;
          st[4] = 1'b0;
          irqSt[EV_WDT] = 1'b1;
        end
        6: begin
          pulse(3);
          st[4:3] = 2'b00;
          pc = curPc + 16'h1;
          irqSt[EV_WDTWAKE] = 1'b1;
        end
        7: begin
          pulse(7);
          st[4:3] = 2'b10;
          pc = (global_irq_enable && pendingIrq) ? PC_VECTOR : curPc + 16'h1;
          irqSt[EV_IRQWAKE] = 1'b1;
        end
        8: begin
          pulse(4);
          power_control_flags[2] = 1'b0;
          irqSt[EV_RI] = 1'b1;
        end
        default: begin
          pulse(c - 4);
          power_control_flags[c == 9 ? 7 : 6] = 1'b1;
          irqSt[EV_STK] = 1'b1;
        end
      endcase
      // a wake keeps gie unless it vectors, every reset drops it
      if (c < 6 || c > 7 || pc == PC_VECTOR) global_irq_enable = 1'b0;
      asleep <= 1'b0;
      repeat (5) @(posedge mclk);
      rdchk("power_control_flags", {1'b0, ADDR_PWRCTL}, {24'h0, power_control_flags});
      rdchk("status", {1'b0, ADDR_STATUS}, {27'h0, st});
      chk("startPc", 32'(startPc_ff), 32'(pc));
      chk("gie", 32'(gieOut), 32'(global_irq_enable));
      chk("push", pushes, 32'(pc == PC_VECTOR));
      chk("coreReset", resets, 32'(c != 6 && c != 7));
      chk("pcLoads", loads, 32'(1 + (pc == PC_VECTOR)));
      rdchk("irqstat", {1'b0, ADDR_IRQSTAT}, {23'h0, irqSt});
      chk("irq", 32'(irq_ff), 32'(|(irqSt & mask)));
      bus(1'b1, {1'b0, ADDR_IRQSTAT}, {23'h0, irqSt});
      repeat (2) @(posedge mclk);
      chk("irq clr", 32'(irq_ff), 32'h0);
      $display("event test %0d cause %0d done", i, c);
    end
    rdchk("unmapped", 5'h1c, 32'h0);
    close_out();
  end
endmodule : tb_top
